// [bench/sgm_modulator_assertions.sv]
`timescale 1ns/1ps
`default_nettype none

module sgm_modulator_assertions (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic modulator_power_gate,
  input wire sgm_pkg::sgm_bus_req_t bus_req,
  input wire logic [7:0] rd_data,
  input wire logic [15:0] high_carrier_sources,
  input wire logic [15:0] low_carrier_sources,
  input wire logic [23:0] modulator_sources,
  input wire logic modulator_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  logic en_r;
  logic [7:0] ctl1_r;

  // shadow of the bits the checker compares against
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_r <= 1'h0;
      ctl1_r <= 8'h00;
    end else if (modulator_power_gate) begin
      en_r <= 1'h0;
      ctl1_r <= 8'h00;
    end else if (bus_req.wr) begin
      if (bus_req.addr == sgm_pkg::OFS_CONTROL_0) en_r <= bus_req.wdata[sgm_pkg::BIT_ENABLE];
      if (bus_req.addr == sgm_pkg::OFS_CONTROL_1) ctl1_r <= bus_req.wdata & 8'h33;
    end
  end

  sequence s_rd(logic [11:0] a);
    bus_req.rd && bus_req.addr == a;
  endsequence

  sequence s_gate_rd;
    modulator_power_gate ##1 s_rd(12'hF4D);
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  AST_GATE_PIN: assert property (modulator_power_gate [*2] |=> !modulator_out)
    else $error("pin high while gated");
  AST_GATE_CLEARS: assert property (s_gate_rd |=> rd_data == 8'h00)
    else $error("gate kept a register");
  AST_DISABLED_LOW: assert property (!en_r [*2] |=> !modulator_out)
    else $error("pin high while disabled");
  AST_STATUS: assert property (s_rd(12'hF4C) |=> rd_data[5] == $past(modulator_out))
    else $error("status bit wrong");
  AST_CTL0_FIELDS: assert property (s_rd(12'hF4C) |=> {rd_data[7:6], rd_data[3:1]} == {$past(en_r), 4'h0})
    else $error("control 0 readback wrong");
  AST_CTL1_RB: assert property (s_rd(12'hF4D) |=> rd_data == $past(ctl1_r))
    else $error("control 1 readback wrong");
  AST_SRC_FIELD: assert property (s_rd(12'hF4E) |=> rd_data[7:5] == 3'h0)
    else $error("source field too wide");
  AST_CAR_FIELD: assert property ((s_rd(12'hF4F) or s_rd(12'hF50)) |=> rd_data[7:4] == 4'h0)
    else $error("carrier field too wide");
endmodule

bind sgm_modulator sgm_modulator_assertions sgm_modulator_assertions_inst (
  .ref_clk(ref_clk),
  .rst_n(rst_n),
  .modulator_power_gate(modulator_power_gate),
  .bus_req(bus_req),
  .rd_data(rd_data),
  .high_carrier_sources(high_carrier_sources),
  .low_carrier_sources(low_carrier_sources),
  .modulator_sources(modulator_sources),
  .modulator_out(modulator_out)
);

`default_nettype wire

// [bench/sgm_pin_load.sv]
`timescale 1ns/1ps
`default_nettype none

module sgm_pin_load (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic [15:0] rises
);
  logic last_r;

  // counts the pulses that reach the load
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_r <= 1'h0;
      rises <= 16'h0000;
    end else begin
      last_r <= pin;
      if (pin && !last_r) rises <= rises + 16'h0001;
    end
  end
endmodule

`default_nettype wire

// [bench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  logic gate = 1'h0;
  sgm_pkg::sgm_bus_req_t bus_req = '0;
  logic [7:0] rd_data;
  logic [15:0] hi = 16'h0000;
  logic [15:0] lo = 16'h0000;
  logic [23:0] ms = 24'h000000;
  logic pin;
  logic [15:0] rises;
  logic [7:0] rmax [5] = '{8'h11, 8'h33, 8'h1F, 8'h0F, 8'h0F};
  int fails = 0;
  int compares = 0;

  always #2.5 ref_clk = ~ref_clk;

  sgm_modulator sgm_modulator_inst (.ref_clk(ref_clk), .rst_n(rst_n), .modulator_power_gate(gate),
    .bus_req(bus_req), .rd_data(rd_data), .high_carrier_sources(hi), .low_carrier_sources(lo),
    .modulator_sources(ms), .modulator_out(pin));
  sgm_pin_load sgm_pin_load_inst (.ref_clk(ref_clk), .rst_n(rst_n), .pin(pin), .rises(rises));

  task automatic close_out();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    bus_req <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
    @(posedge ref_clk);
    bus_req <= '0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
    @(posedge ref_clk);
    bus_req <= '0;
    #1 chk("rd_data", rd_data, exp);
    @(posedge ref_clk);
  endtask

  // the pin settles two edges after its cause; four leaves margin
  task automatic po(input logic exp);
    repeat (4) @(posedge ref_clk);
    #1 chk("modulator_out", {7'h00, pin}, {7'h00, exp});
    @(posedge ref_clk);
  endtask

  initial begin
    repeat (5000) @(posedge ref_clk);
    fails++;
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'h1;
    @(posedge ref_clk);
    for (int i = 0; i < 5; i++) rd(12'hF4C + 12'(i), 8'h00);
    wr(12'hF51, 8'hFF);
    rd(12'hF51, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(12'hF4C + 12'(i), i == 0 ? 8'h7F : 8'hFF);
      rd(12'hF4C + 12'(i), rmax[i]);
    end
    wr(12'hF4C, 8'h80);
    po(1'h1);
    gate <= 1'h1;
    repeat (2) @(posedge ref_clk);
    gate <= 1'h0;
    rd(12'hF4D, 8'h00);
    for (int i = 0; i < 5; i++) rd(12'hF4C + 12'(i), 8'h00);
    wr(12'hF4E, 8'h01);
    for (int s = 0; s < 2; s++) begin
      wr(12'hF4C, s ? 8'h80 : 8'h81);
      for (int c = 0; c < 16; c++) begin
        wr(s ? 12'hF4F : 12'hF50, 8'(c));
        hi <= s ? 16'h0000 : 16'h0001 << c;
        lo <= s ? 16'h0001 << c : 16'h0000;
        po(1'h1);
        hi <= s ? 16'h0000 : ~(16'h0001 << c);
        lo <= s ? ~(16'h0001 << c) : 16'h0000;
        po(1'h0);
      end
    end
    wr(12'hF4D, 8'h02);
    po(1'h1);
    wr(12'hF4C, 8'h90);
    po(1'h0);
    wr(12'hF4D, 8'h00);
    po(1'h1);
    rd(12'hF4C, 8'hB0);
    wr(12'hF4C, 8'h81);
    po(1'h0);
    wr(12'hF4D, 8'h20);
    po(1'h1);
    wr(12'hF4C, 8'h11);
    po(1'h0);
    rd(12'hF4D, 8'h20);
    wr(12'hF4E, 8'h00);
    wr(12'hF4C, 8'h81);
    po(1'h0);
    ms <= 24'h000001;
    po(1'h1);
    wr(12'hF4E, 8'h18);
    ms <= 24'hFFFFFF;
    po(1'h0);
    wr(12'hF4E, 8'h17);
    wr(12'hF4D, 8'h30);
    po(1'h1);
    ms <= 24'h000000;
    po(1'h1);
    hi <= 16'hFFFF;
    lo <= 16'hFFFF;
    po(1'h1);
    wr(12'hF4D, 8'h20);
    lo <= 16'h0000;
    hi <= 16'h0000;
    ms <= 24'hFFFFFF;
    po(1'h1);
    wr(12'hF4D, 8'h21);
    ms <= 24'h000000;
    po(1'h0);
    ms <= 24'hFFFFFF;
    po(1'h0);
    chk("pin_rises", {7'h00, rises != 16'h0000}, 8'h01);
    rst_n <= 1'h0;
    @(posedge ref_clk);
    rst_n <= 1'h1;
    @(posedge ref_clk);
    rd(12'hF4D, 8'h00);
    po(1'h0);
    close_out();
  end
endmodule

`default_nettype wire

// [design/sgm_carrier_path.sv]
`timescale 1ns/1ps
`default_nettype none

module sgm_carrier_path (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic [15:0] sources,
  input wire sgm_pkg::sgm_carrier_cfg_t cfg,
  output logic carrier,
  output logic carrier_fall
);

  logic picked;
  logic prev_r;
  logic prev_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // source pick and polarity; the edge below is taken after inversion
  assign picked = sources[cfg.source];
  assign carrier = picked ^ cfg.polarity;
  assign carrier_fall = prev_r & ~carrier;
  assign prev_nxt = clear ? 1'b0 : carrier;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
    end
  end

endmodule

`default_nettype wire

// [design/sgm_modulator.sv]
`timescale 1ns/1ps
`default_nettype none

module sgm_modulator (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic modulator_power_gate,
  input wire sgm_pkg::sgm_bus_req_t bus_req,
  output logic [7:0] rd_data,
  input wire logic [15:0] high_carrier_sources,
  input wire logic [15:0] low_carrier_sources,
  input wire logic [23:0] modulator_sources,
  output logic modulator_out
);

  ////////////////////////////////////////////////////////////////////////////
  // source decode for the mixing path; the status view reads the registered pin instead
  function automatic logic sgm_pick_modulator(
    input logic [4:0] code,
    input logic [23:0] vec,
    input logic soft_bit
  );
    logic res;
    res = 1'b0;
    if (code == sgm_pkg::SRC_SOFTWARE_BIT) begin
      res = soft_bit;
    end else if (code < sgm_pkg::SRC_FIRST_RESERVED) begin
      res = vec[code];
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic enable_r;
  logic enable_nxt;
  logic out_polarity_r;
  logic out_polarity_nxt;
  logic soft_bit_r;
  logic soft_bit_nxt;
  logic [7:0] control_1_r;
  logic [7:0] control_1_nxt;
  logic [4:0] source_r;
  logic [4:0] source_nxt;
  logic [3:0] low_sel_r;
  logic [3:0] low_sel_nxt;
  logic [3:0] high_sel_r;
  logic [3:0] high_sel_nxt;
  logic [7:0] rd_data_r;
  logic [7:0] rd_data_nxt;
  logic out_r;
  logic out_nxt;
  sgm_pkg::sgm_car_state_t state_r;
  sgm_pkg::sgm_car_state_t state_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  wire hit_control_0 = bus_req.addr == sgm_pkg::OFS_CONTROL_0;
  wire hit_control_1 = bus_req.addr == sgm_pkg::OFS_CONTROL_1;
  wire hit_source = bus_req.addr == sgm_pkg::OFS_SOURCE_SELECT;
  wire hit_low = bus_req.addr == sgm_pkg::OFS_LOW_CARRIER;
  wire hit_high = bus_req.addr == sgm_pkg::OFS_HIGH_CARRIER;

  // writes are ignored while the block is power gated
  wire wr_ok = bus_req.wr & ~modulator_power_gate;
  wire wr_control_0 = wr_ok & hit_control_0;
  wire wr_control_1 = wr_ok & hit_control_1;
  wire wr_source = wr_ok & hit_source;
  wire wr_low = wr_ok & hit_low;
  wire wr_high = wr_ok & hit_high;

  ////////////////////////////////////////////////////////////////////////////
  // next register values; the gate forces reset values each cycle
  wire gate = modulator_power_gate;

  assign enable_nxt = gate ? sgm_pkg::RST_CONTROL_0[sgm_pkg::BIT_ENABLE] :
    wr_control_0 ? bus_req.wdata[sgm_pkg::BIT_ENABLE] : enable_r;
  assign out_polarity_nxt = gate ? sgm_pkg::RST_CONTROL_0[sgm_pkg::BIT_OUTPUT_POLARITY] :
    wr_control_0 ? bus_req.wdata[sgm_pkg::BIT_OUTPUT_POLARITY] : out_polarity_r;
  assign soft_bit_nxt = gate ? sgm_pkg::RST_CONTROL_0[sgm_pkg::BIT_SOFTWARE_MODULATION] :
    wr_control_0 ? bus_req.wdata[sgm_pkg::BIT_SOFTWARE_MODULATION] : soft_bit_r;

  // only the documented control 1 bits are held
  wire [7:0] control_1_mask = 8'h33;
  assign control_1_nxt = gate ? sgm_pkg::RST_CONTROL_1 :
    wr_control_1 ? (bus_req.wdata & control_1_mask) : control_1_r;

  assign source_nxt = gate ? sgm_pkg::RST_SOURCE_SELECT :
    wr_source ? bus_req.wdata[4:0] : source_r;
  assign low_sel_nxt = gate ? sgm_pkg::RST_CARRIER_SELECT :
    wr_low ? bus_req.wdata[3:0] : low_sel_r;
  assign high_sel_nxt = gate ? sgm_pkg::RST_CARRIER_SELECT :
    wr_high ? bus_req.wdata[3:0] : high_sel_r;

  ////////////////////////////////////////////////////////////////////////////
  // carrier configuration
  sgm_pkg::sgm_carrier_cfg_t high_cfg;
  sgm_pkg::sgm_carrier_cfg_t low_cfg;

  assign high_cfg.source = high_sel_r;
  assign high_cfg.polarity = control_1_r[sgm_pkg::BIT_HIGH_CARRIER_POLARITY];
  assign high_cfg.sync = control_1_r[sgm_pkg::BIT_HIGH_CARRIER_SYNC];
  assign low_cfg.source = low_sel_r;
  assign low_cfg.polarity = control_1_r[sgm_pkg::BIT_LOW_CARRIER_POLARITY];
  assign low_cfg.sync = control_1_r[sgm_pkg::BIT_LOW_CARRIER_SYNC];

  logic high_carrier;
  logic high_fall;
  logic low_carrier;
  logic low_fall;
  wire path_clear = gate | ~enable_r;

  sgm_carrier_path u_high_path (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clear(path_clear),
    .sources(high_carrier_sources),
    .cfg(high_cfg),
    .carrier(high_carrier),
    .carrier_fall(high_fall)
  );

  sgm_carrier_path u_low_path (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clear(path_clear),
    .sources(low_carrier_sources),
    .cfg(low_cfg),
    .carrier(low_carrier),
    .carrier_fall(low_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // modulator signal
  wire modulator = sgm_pick_modulator(source_r, modulator_sources, soft_bit_r);

  ////////////////////////////////////////////////////////////////////////////
  // carrier hand-over: a pending switch keeps the old carrier until it falls
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      sgm_pkg::SGM_CAR_LOW: begin
        if (modulator) begin
          if (low_cfg.sync && !low_fall) begin
            state_nxt = sgm_pkg::SGM_CAR_TO_HIGH;
          end else begin
            state_nxt = sgm_pkg::SGM_CAR_HIGH;
          end
        end
      end
      sgm_pkg::SGM_CAR_TO_HIGH: begin
        if (!modulator) begin
          state_nxt = sgm_pkg::SGM_CAR_LOW;
        end else if (low_fall) begin
          state_nxt = sgm_pkg::SGM_CAR_HIGH;
        end
      end
      sgm_pkg::SGM_CAR_HIGH: begin
        if (!modulator) begin
          if (high_cfg.sync && !high_fall) begin
            state_nxt = sgm_pkg::SGM_CAR_TO_LOW;
          end else begin
            state_nxt = sgm_pkg::SGM_CAR_LOW;
          end
        end
      end
      sgm_pkg::SGM_CAR_TO_LOW: begin
        if (modulator) begin
          state_nxt = sgm_pkg::SGM_CAR_HIGH;
        end else if (high_fall) begin
          state_nxt = sgm_pkg::SGM_CAR_LOW;
        end
      end
      default: begin
        state_nxt = sgm_pkg::SGM_CAR_LOW;
      end
    endcase
    if (path_clear) begin
      state_nxt = sgm_pkg::SGM_CAR_LOW;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mixing and output polarity
  wire use_high = (state_r == sgm_pkg::SGM_CAR_HIGH) || (state_r == sgm_pkg::SGM_CAR_TO_LOW);
  wire mixed = use_high ? high_carrier : low_carrier;
  wire polarized = mixed ^ out_polarity_r;

  // a disabled or gated block holds the pin low whatever the polarity
  assign out_nxt = (enable_r && !gate) ? polarized : 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // read path; the status bit is out_r, the same register that drives
  // modulator_out, so it always shows the pin level of that cycle
  wire [7:0] control_0_view = {
    enable_r,
    1'b0,
    out_r,
    out_polarity_r,
    3'b000,
    soft_bit_r
  };

  wire [7:0] rd_mux =
    hit_control_0 ? control_0_view :
    hit_control_1 ? control_1_r :
    hit_source ? {3'b000, source_r} :
    hit_low ? {4'h0, low_sel_r} :
    hit_high ? {4'h0, high_sel_r} :
    8'h00;

  assign rd_data_nxt = bus_req.rd ? rd_mux : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_r <= 1'b0;
      out_polarity_r <= 1'b0;
      soft_bit_r <= 1'b0;
      control_1_r <= sgm_pkg::RST_CONTROL_1;
      source_r <= sgm_pkg::RST_SOURCE_SELECT;
      low_sel_r <= sgm_pkg::RST_CARRIER_SELECT;
      high_sel_r <= sgm_pkg::RST_CARRIER_SELECT;
    end else begin
      enable_r <= enable_nxt;
      out_polarity_r <= out_polarity_nxt;
      soft_bit_r <= soft_bit_nxt;
      control_1_r <= control_1_nxt;
      source_r <= source_nxt;
      low_sel_r <= low_sel_nxt;
      high_sel_r <= high_sel_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= sgm_pkg::SGM_CAR_LOW;
      out_r <= 1'b0;
      rd_data_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      out_r <= out_nxt;
      rd_data_r <= rd_data_nxt;
    end
  end

  assign modulator_out = out_r;
  assign rd_data = rd_data_r;

endmodule

`default_nettype wire

// [pkg/sgm_pkg.sv]
`default_nettype none

package sgm_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [11:0] OFS_CONTROL_0 = 12'hF4C;
  localparam logic [11:0] OFS_CONTROL_1 = 12'hF4D;
  localparam logic [11:0] OFS_SOURCE_SELECT = 12'hF4E;
  localparam logic [11:0] OFS_LOW_CARRIER = 12'hF4F;
  localparam logic [11:0] OFS_HIGH_CARRIER = 12'hF50;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] RST_CONTROL_0 = 8'h00;
  localparam logic [7:0] RST_CONTROL_1 = 8'h00;
  localparam logic [4:0] RST_SOURCE_SELECT = 5'h00;
  localparam logic [3:0] RST_CARRIER_SELECT = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // field positions, control 0
  localparam int unsigned BIT_ENABLE = 7;
  localparam int unsigned BIT_OUT_STATUS = 5;
  localparam int unsigned BIT_OUTPUT_POLARITY = 4;
  localparam int unsigned BIT_SOFTWARE_MODULATION = 0;

  // field positions, control 1
  localparam int unsigned BIT_HIGH_CARRIER_POLARITY = 5;
  localparam int unsigned BIT_HIGH_CARRIER_SYNC = 4;
  localparam int unsigned BIT_LOW_CARRIER_POLARITY = 1;
  localparam int unsigned BIT_LOW_CARRIER_SYNC = 0;

  // field widths
  localparam int unsigned SOURCE_W = 5;
  localparam int unsigned CARRIER_SEL_W = 4;
  localparam int unsigned CARRIER_SOURCES = 16;
  localparam int unsigned MODULATOR_SOURCES = 24;

  ////////////////////////////////////////////////////////////////////////////
  // modulator source codes
  localparam logic [4:0] SRC_PIN = 5'h00;
  localparam logic [4:0] SRC_SOFTWARE_BIT = 5'h01;
  localparam logic [4:0] SRC_FIRST_RESERVED = 5'h18;

  ////////////////////////////////////////////////////////////////////////////
  // carrier selection state
  typedef enum logic [1:0] {
    SGM_CAR_LOW = 2'b00,
    SGM_CAR_TO_HIGH = 2'b01,
    SGM_CAR_HIGH = 2'b11,
    SGM_CAR_TO_LOW = 2'b10
  } sgm_car_state_t;

  // register bus request
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sgm_bus_req_t;

  // one carrier's configuration
  typedef struct packed {
    logic [3:0] source;
    logic polarity;
    logic sync;
  } sgm_carrier_cfg_t;

endpackage

`default_nettype wire
